/* bench/irq_far_side.sv */
// Far side model: external request logic and cpu acknowledge.
`timescale 1ns/1ps
module irq_far_side (
  // Clock and control
  input wire logic clock,
  input wire logic resetn,
  input wire logic [3:0] want_code,
  input wire logic auto_ack,
  input wire logic skip_hold,
  // Device side
  input wire logic irq_req,
  input wire logic [11:0] event_code_register,
  output logic [3:0] encoded_level_inputs,
  output logic cpu_ack
);
  import irq_front_pkg::*;
  logic accepted_ff;
  logic [3:0] level_ff;
  logic ack_ff;
  assign encoded_level_inputs = level_ff;
  assign cpu_ack = ack_ff;
  // ----------------------------------------
  // Request hold and acknowledge
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      level_ff <= IRL_NONE;
      accepted_ff <= 1'b0;
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= auto_ack && irq_req && !ack_ff;
      // Lower only once accepted or with skip_hold set, raise at once
      if (want_code != level_ff && (want_code < level_ff || accepted_ff || skip_hold)) begin
        level_ff <= want_code;
        accepted_ff <= 1'b0;
      end else if (ack_ff && event_code_register != CODE_NMI) begin
        accepted_ff <= 1'b1;
      end
    end
  end
endmodule

/* bench/irq_front_chk.sv */
// Port assertions for the interrupt front end.
`timescale 1ns/1ps
module irq_front_chk (
  // Clock and bus
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic hreadyout,
  input wire logic hresp,
  // Cpu side
  input wire logic [3:0] cpu_mask_level,
  input wire logic cpu_ack,
  input wire logic irq_req,
  input wire logic [4:0] irq_level,
  input wire logic [11:0] event_code_register
);
  import irq_front_pkg::*;
  logic is_nmi;
  logic is_enc;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  assign is_nmi = event_code_register == CODE_NMI;
  assign is_enc = !is_nmi && event_code_register < CODE_PERIPH_BASE;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_bus_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_ready_enable: assert property (hreadyout == clk_en)
    else $error("hreadyout differs from enable");
  a_nmi_top_level: assert property (irq_req && is_nmi |-> irq_level == LEVEL_NMI)
    else $error("nmi request not at top level");
  a_nmi_stands: assert property (irq_req && is_nmi && !cpu_ack && !$past(cpu_ack)
      |=> irq_req && is_nmi)
    else $error("nmi request dropped before ack");
  a_level_range: assert property (irq_req |-> irq_level inside {[1:16]})
    else $error("request level out of range");
  a_mask_exceed: assert property (irq_req && !is_nmi && $stable(cpu_mask_level)
      |-> irq_level > {1'b0, cpu_mask_level})
    else $error("request not above mask level");
  a_enc_code: assert property (irq_req && is_enc
      |-> event_code_register == CODE_IRL_BASE + 12'(5'd15 - irq_level) * CODE_STEP)
    else $error("encoded code does not match level");
  a_periph_level: assert property (irq_req && !is_nmi && !is_enc
      |-> irq_level inside {[1:15]})
    else $error("peripheral level out of range");
  c_nmi_req: cover property (irq_req && is_nmi);
  c_enc_req: cover property (irq_req && is_enc);
  c_cpu_ack: cover property (cpu_ack && irq_req);
endmodule

bind nmi_irl_interrupt_front_end irq_front_chk irq_front_chk_inst (
  .clock(clock), .resetn(resetn), .clk_en(clk_en), .hreadyout(hreadyout),
  .hresp(hresp), .cpu_mask_level(cpu_mask_level), .cpu_ack(cpu_ack),
  .irq_req(irq_req), .irq_level(irq_level), .event_code_register(event_code_register)
);

/* bench/nmi_irl_interrupt_front_end_tb_top.sv */
// Testbench: register, nmi and encoded request scenarios.
`timescale 1ns/1ps
module nmi_irl_interrupt_front_end_tb_top;
  import irq_front_pkg::*;
  logic clock;
  logic resetn;
  logic manual_reset;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic nmi_pin;
  logic [3:0] encoded_level_inputs;
  logic [NUM_PERIPH-1:0] periph_req;
  logic cpu_block_bit;
  logic [3:0] cpu_mask_level;
  logic sleep_mode;
  logic standby_mode;
  logic rtc_clk_pin;
  logic cpu_ack;
  logic irq_req;
  logic [4:0] irq_level;
  logic [11:0] event_code_register;
  logic [3:0] want_code;
  logic auto_ack;
  logic skip_hold;
  logic [31:0] rd_q;
  int n_errors;
  int checked;

  nmi_irl_interrupt_front_end nmi_irl_interrupt_front_end_inst (
    .clock(clock), .resetn(resetn), .clk_en(1'b1), .manual_reset(manual_reset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .nmi_pin(nmi_pin), .encoded_level_inputs(encoded_level_inputs),
    .rtc_clk_pin(rtc_clk_pin), .periph_req(periph_req), .cpu_block_bit(cpu_block_bit),
    .cpu_mask_level(cpu_mask_level), .sleep_mode(sleep_mode), .standby_mode(standby_mode),
    .cpu_ack(cpu_ack), .irq_req(irq_req), .irq_level(irq_level),
    .event_code_register(event_code_register)
  );
  irq_far_side irq_far_side_inst (
    .clock(clock), .resetn(resetn), .want_code(want_code), .auto_ack(auto_ack),
    .skip_hold(skip_hold), .irq_req(irq_req), .event_code_register(event_code_register),
    .encoded_level_inputs(encoded_level_inputs), .cpu_ack(cpu_ack)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out();
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd_q = hrdata;
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk("read data", rd_q, exp);
  endtask
  task automatic wait_for(input logic [4:0] lv, input logic [11:0] cd);
    int i;
    for (i = 0; i < 40 && {irq_req, irq_level, event_code_register} !== {1'b1, lv, cd}; i++)
      @(posedge clock);
    chk("irq", 32'({irq_req, irq_level, event_code_register}), 32'({1'b1, lv, cd}));
  endtask
  task automatic quiet(input int n);
    repeat (n) @(posedge clock);
    chk("irq_req", 32'(irq_req), 32'h0);
  endtask

  // ----------------------------------------
  // Clock, watchdog and scenarios
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    close_out();
  end
  initial begin
    resetn = 1'b0;
    manual_reset = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    nmi_pin = 1'b1;
    periph_req = '0;
    cpu_block_bit = 1'b0;
    cpu_mask_level = 4'h0;
    sleep_mode = 1'b0;
    standby_mode = 1'b0;
    rtc_clk_pin = 1'b0;
    want_code = IRL_NONE;
    auto_ack = 1'b1;
    skip_hold = 1'b0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    rdchk(ADDR_CONTROL, 32'h8000);
    rdchk(ADDR_PRIO_D, 32'(RST_PRIO_D));
    rdchk(ADDR_MASK_SET, RST_MASK);
    rdchk(ADDR_EXT_PRIO_MAP, RST_EXT_PRIO_MAP);
    rdchk(ADDR_PRIO_A, 32'(RST_PRIO_ABC));
    rdchk(32'hfe0800f0, 32'h0);
    nmi_pin <= 1'b0;
    wait_for(LEVEL_NMI, CODE_NMI);
    rdchk(ADDR_CONTROL, 32'h0);
    quiet(1);
    bus(1'b1, ADDR_CONTROL, 32'h0100);
    repeat (10) @(posedge clock);
    nmi_pin <= 1'b1;
    wait_for(LEVEL_NMI, CODE_NMI);
    quiet(3);
    auto_ack <= 1'b0;
    nmi_pin <= 1'b0;
    quiet(15);
    cpu_block_bit <= 1'b1;
    auto_ack <= 1'b1;
    bus(1'b1, ADDR_CONTROL, 32'h0300);
    repeat (10) @(posedge clock);
    nmi_pin <= 1'b1;
    wait_for(LEVEL_NMI, CODE_NMI);
    bus(1'b1, ADDR_CONTROL, 32'h0100);
    sleep_mode <= 1'b1;
    nmi_pin <= 1'b0;
    repeat (10) @(posedge clock);
    nmi_pin <= 1'b1;
    wait_for(LEVEL_NMI, CODE_NMI);
    quiet(3);
    sleep_mode <= 1'b0;
    auto_ack <= 1'b0;
    nmi_pin <= 1'b0;
    repeat (10) @(posedge clock);
    nmi_pin <= 1'b1;
    quiet(15);
    cpu_block_bit <= 1'b0;
    auto_ack <= 1'b1;
    wait_for(LEVEL_NMI, CODE_NMI);
    for (int c = 0; c < 15; c++) begin
      want_code <= 4'(c);
      wait_for(5'(15 - c), CODE_IRL_BASE + 12'(c) * CODE_STEP);
    end
    want_code <= IRL_NONE;
    quiet(20);
    skip_hold <= 1'b1;
    want_code <= 4'h0;
    repeat (2) @(posedge clock);
    want_code <= IRL_NONE;
    quiet(20);
    skip_hold <= 1'b0;
    cpu_mask_level <= 4'hf;
    want_code <= 4'h0;
    quiet(20);
    cpu_mask_level <= 4'he;
    wait_for(5'd15, CODE_IRL_BASE);
    cpu_mask_level <= 4'h0;
    want_code <= IRL_NONE;
    quiet(20);
    bus(1'b1, ADDR_CONTROL, 32'h0180);
    want_code <= 4'he;
    wait_for(5'd13, CODE_IRL0);
    want_code <= IRL_NONE;
    repeat (20) @(posedge clock);
    bus(1'b1, ADDR_CONTROL, 32'h0100);
    quiet(20);
    standby_mode <= 1'b1;
    want_code <= 4'h3;
    quiet(30);
    repeat (8) begin
      rtc_clk_pin <= ~rtc_clk_pin;
      repeat (4) @(posedge clock);
    end
    wait_for(5'd12, CODE_IRL_BASE + 12'h060);
    standby_mode <= 1'b0;
    want_code <= IRL_NONE;
    quiet(20);
    periph_req[1:0] <= 2'h3;
    bus(1'b1, ADDR_PRIO_A, 32'h55);
    wait_for(5'd5, CODE_PERIPH_BASE);
    bus(1'b1, ADDR_PRIO_A, 32'h0);
    quiet(5);
    periph_req[1:0] <= 2'h0;
    periph_req[12] <= 1'b1;
    bus(1'b1, ADDR_PRIO_A, 32'h1234);
    rdchk(ADDR_PENDING, 32'h0);
    bus(1'b1, ADDR_MASK_CLEAR, 32'h3ff);
    rdchk(ADDR_MASK_SET, 32'h0);
    rdchk(ADDR_PENDING, 32'h1);
    rdchk(ADDR_PRIO_A, 32'h1234);
    manual_reset <= 1'b1;
    @(posedge clock);
    manual_reset <= 1'b0;
    rdchk(ADDR_PRIO_A, 32'h0);
    rdchk(ADDR_MASK_SET, RST_MASK);
    close_out();
  end
endmodule

/* logic/nmi_irl_interrupt_front_end.sv */
// Interrupt front end: nmi edge detect, encoded level filter, priority resolve, registers.
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module nmi_irl_interrupt_front_end (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic manual_reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Pins
  input wire logic nmi_pin,
  input wire logic [3:0] encoded_level_inputs,
  input wire logic rtc_clk_pin,
  // Peripheral request levels
  input wire logic [irq_front_pkg::NUM_PERIPH-1:0] periph_req,
  // Cpu side
  input wire logic cpu_block_bit,
  input wire logic [3:0] cpu_mask_level,
  input wire logic sleep_mode,
  input wire logic standby_mode,
  input wire logic cpu_ack,
  output logic irq_req,
  output logic [4:0] irq_level,
  output logic [11:0] event_code_register
);
  import irq_front_pkg::*;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [31:0] ext_map_ff;
  logic [31:0] mask_ff;
  logic [15:0] prio_a_ff;
  logic [15:0] prio_b_ff;
  logic [15:0] prio_c_ff;
  logic [15:0] prio_d_ff;
  logic edge_sel_ff;
  logic accept_all_ff;
  logic indep_ff;

  // Bus state
  logic wr_pend_ff;
  logic [31:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic addr_phase;
  logic wr_en;

  // Pin synchronisers
  logic [2:0] nmi_sync_ff;
  logic [3:0] irl_s1_ff;
  logic [3:0] irl_s2_ff;
  logic [3:0] irl_s3_ff;
  logic [2:0] rtc_sync_ff;

  // Nmi path
  logic nmi_lvl_ff;
  logic [1:0] nmi_prime_ff;
  logic [2:0] blind_ff;
  logic nmi_pend_ff;
  logic nmi_edge;
  logic nmi_ok;

  // Encoded level filter
  logic [3:0] irl_in_ff;
  logic [3:0] irl_cand_ff;
  logic [1:0] irl_cnt_ff;
  logic [3:0] irl_ff;
  logic sample_en;

  // Resolve
  logic [4:0] cand_lvl [NUM_CAND];
  logic [11:0] cand_code [NUM_CAND];
  logic [4:0] best_lvl;
  logic [11:0] best_code;
  logic [31:0] pending;
  logic [15:0] ctl_read;
  logic [31:0] rd_mux;
  logic [NUM_PERIPH*4-1:0] periph_prio;

  // ------------------------------------------------------------
  // AHB-Lite slave: zero wait, always OKAY
  // ------------------------------------------------------------
  assign hreadyout = clk_en;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign addr_phase = hsel && htrans[1] && hready;
  assign wr_en = clk_en && wr_pend_ff;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 32'h00000000;
    end else if (clk_en) begin
      wr_pend_ff <= addr_phase && hwrite;
      wr_addr_ff <= haddr;
    end
  end

  // Read data captured at the address phase edge
  assign ctl_read = {nmi_lvl_ff, 5'h00, accept_all_ff, edge_sel_ff, indep_ff, 7'h00}; // [R15] [R16]

  always_comb begin
    case (haddr)
      ADDR_EXT_PRIO_MAP: rd_mux = ext_map_ff;
      ADDR_PENDING: rd_mux = pending;
      ADDR_MASK_SET: rd_mux = mask_ff;
      ADDR_CONTROL: rd_mux = {16'h0000, ctl_read};
      ADDR_PRIO_A: rd_mux = {16'h0000, prio_a_ff};
      ADDR_PRIO_B: rd_mux = {16'h0000, prio_b_ff};
      ADDR_PRIO_C: rd_mux = {16'h0000, prio_c_ff};
      ADDR_PRIO_D: rd_mux = {16'h0000, prio_d_ff};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hrdata_ff <= 32'h00000000;
    end else if (clk_en && addr_phase && !hwrite) begin
      hrdata_ff <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // Register writes, power-on and manual reset
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ext_map_ff <= RST_EXT_PRIO_MAP;
      mask_ff <= RST_MASK;
      prio_a_ff <= RST_PRIO_ABC;
      prio_b_ff <= RST_PRIO_ABC;
      prio_c_ff <= RST_PRIO_ABC;
      prio_d_ff <= RST_PRIO_D;
      edge_sel_ff <= 1'b0;
      accept_all_ff <= 1'b0;
      indep_ff <= 1'b0;
    end else if (clk_en && manual_reset) begin
      ext_map_ff <= RST_EXT_PRIO_MAP; // [R17]
      mask_ff <= RST_MASK; // [R17]
      prio_a_ff <= RST_PRIO_ABC;
      prio_b_ff <= RST_PRIO_ABC;
      prio_c_ff <= RST_PRIO_ABC;
      prio_d_ff <= RST_PRIO_D; // [R17]
      edge_sel_ff <= 1'b0;
      accept_all_ff <= 1'b0;
      indep_ff <= 1'b0;
    end else if (wr_en) begin
      case (wr_addr_ff)
        ADDR_EXT_PRIO_MAP: ext_map_ff <= hwdata; // [R18]
        ADDR_MASK_SET: mask_ff <= mask_ff | hwdata;
        ADDR_MASK_CLEAR: mask_ff <= mask_ff & ~hwdata;
        ADDR_CONTROL: begin
          edge_sel_ff <= hwdata[CTL_EDGE_SEL_BIT]; // [R5]
          accept_all_ff <= hwdata[CTL_ACCEPT_ALL_BIT]; // [R4]
          indep_ff <= hwdata[CTL_INDEP_BIT]; // [R13]
        end
        ADDR_PRIO_A: prio_a_ff <= hwdata[15:0]; // [R18]
        ADDR_PRIO_B: prio_b_ff <= hwdata[15:0];
        ADDR_PRIO_C: prio_c_ff <= hwdata[15:0];
        ADDR_PRIO_D: prio_d_ff <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      nmi_sync_ff <= 3'h0;
      irl_s1_ff <= IRL_NONE;
      irl_s2_ff <= IRL_NONE;
      irl_s3_ff <= IRL_NONE;
      rtc_sync_ff <= 3'h0;
    end else if (clk_en) begin
      nmi_sync_ff <= {nmi_sync_ff[1:0], nmi_pin};
      irl_s1_ff <= encoded_level_inputs;
      irl_s2_ff <= irl_s1_ff;
      irl_s3_ff <= irl_s2_ff;
      rtc_sync_ff <= {rtc_sync_ff[1:0], rtc_clk_pin};
    end
  end

  // ------------------------------------------------------------
  // Nmi level, edge detect and blind window
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      nmi_lvl_ff <= 1'b0;
      nmi_prime_ff <= 2'd0;
    end else if (clk_en) begin
      if (nmi_sync_ff[1] == nmi_sync_ff[2]) begin
        nmi_lvl_ff <= nmi_sync_ff[2]; // [R15] [R16]
      end
      if (nmi_prime_ff != NMI_PRIME_CYCLES) begin
        nmi_prime_ff <= nmi_prime_ff + 2'd1;
      end
    end
  end

  // Pin level at reset must not count as an edge
  assign nmi_edge = (nmi_prime_ff == NMI_PRIME_CYCLES) && (blind_ff == 3'd0)
    && (nmi_sync_ff[1] == nmi_sync_ff[2]) && (nmi_sync_ff[2] != nmi_lvl_ff)
    && (nmi_sync_ff[2] == edge_sel_ff); // [R5] [R6]

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      blind_ff <= 3'd0;
    end else if (clk_en) begin
      if (wr_en && wr_addr_ff == ADDR_CONTROL) begin
        blind_ff <= EDGE_BLIND_CYCLES; // [R6]
      end else if (blind_ff != 3'd0) begin
        blind_ff <= blind_ff - 3'd1;
      end
    end
  end

  // Edge set wins over acknowledge clear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      nmi_pend_ff <= 1'b0;
    end else if (clk_en) begin
      if (nmi_edge) begin
        nmi_pend_ff <= 1'b1;
      end else if (cpu_ack && irq_req && event_code_register == CODE_NMI) begin
        nmi_pend_ff <= 1'b0;
      end
    end
  end

  assign nmi_ok = nmi_pend_ff
    && (!cpu_block_bit // [R2]
    || sleep_mode || standby_mode // [R3]
    || accept_all_ff); // [R4]

  // ------------------------------------------------------------
  // Encoded level noise filter
  // ------------------------------------------------------------
  assign sample_en = standby_mode ? (rtc_sync_ff[1] && !rtc_sync_ff[2]) : 1'b1; // [R10]

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irl_in_ff <= IRL_NONE;
    end else if (clk_en && irl_s2_ff == irl_s3_ff) begin
      irl_in_ff <= irl_s3_ff;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irl_cand_ff <= IRL_NONE;
      irl_cnt_ff <= 2'd0;
      irl_ff <= IRL_NONE;
    end else if (clk_en && sample_en) begin // [R9]
      if (irl_in_ff != irl_cand_ff) begin
        irl_cand_ff <= irl_in_ff;
        irl_cnt_ff <= 2'd1;
      end else if (irl_cnt_ff != FILTER_SAMPLES) begin
        irl_cnt_ff <= irl_cnt_ff + 2'd1;
        if (irl_cnt_ff + 2'd1 == FILTER_SAMPLES) begin
          irl_ff <= irl_cand_ff; // [R9]
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Candidate table, index order is the default order
  // ------------------------------------------------------------
  assign periph_prio = {ext_map_ff, prio_c_ff, prio_b_ff, prio_a_ff};
  assign cand_lvl[0] = nmi_ok ? LEVEL_NMI : 5'h00; // [R2]
  assign cand_code[0] = CODE_NMI; // [R20]
  // Encoded mode: code 0000 is level 15, 1111 is none
  assign cand_lvl[1] = indep_ff ? 5'h00 : {1'b0, ~irl_ff}; // [R8] [R13]
  assign cand_code[1] = CODE_IRL_BASE + {3'h0, irl_ff, 5'h00}; // [R20]
  assign cand_code[2] = CODE_IRL0;
  assign cand_code[3] = CODE_IRL1;
  assign cand_code[4] = CODE_IRL2;
  assign cand_code[5] = CODE_IRL3;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_indep
      // Independent mode: active low pin, level from group d
      assign cand_lvl[2+gi] = (indep_ff && !irl_ff[gi])
        ? {1'b0, prio_d_ff[15-4*gi -: 4]} : 5'h00; // [R13]
    end
    for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_periph
      logic src_live;
      if (gi < NUM_GROUP_SRC) begin : g_grp
        assign src_live = periph_req[gi];
      end else begin : g_map
        assign src_live = periph_req[gi] && !mask_ff[gi-NUM_GROUP_SRC];
        assign pending[gi-NUM_GROUP_SRC] = src_live;
      end
      assign cand_lvl[5+1+gi] = src_live ? {1'b0, periph_prio[4*gi +: 4]} : 5'h00; // [R18]
      assign cand_code[5+1+gi] = CODE_PERIPH_BASE + 12'(gi) * CODE_STEP; // [R20]
    end
  endgenerate
  assign pending[31:NUM_MAP_SRC] = '0;

  // Strict compare keeps the earlier source on a tie
  always_comb begin
    best_lvl = 5'h00;
    best_code = 12'h000;
    for (int i = 0; i < NUM_CAND; i++) begin
      if (cand_lvl[i] > best_lvl) begin // [R19] [R1]
        best_lvl = cand_lvl[i];
        best_code = cand_code[i];
      end
    end
  end

  // ------------------------------------------------------------
  // Cpu request; the cpu mask level is only read, never written
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_req <= 1'b0;
      irq_level <= 5'h00;
      event_code_register <= 12'h000;
    end else if (clk_en) begin
      irq_req <= (best_lvl == LEVEL_NMI) // [R14] [R7] [R12]
        || (best_lvl > {1'b0, cpu_mask_level}); // [R21] [R14]
      irq_level <= best_lvl;
      event_code_register <= best_code; // [R20]
    end
  end

endmodule

/* pkg/irq_front_pkg.sv */
// Constants, register map and field layout of the interrupt front end.
// Function
// R1 - Every source has level 16..0; 16 highest, 1 lowest, 0 masks the source.
// R2 - Nonmaskable request has fixed level 16, accepted unless cpu block bit set.
// R3 - In sleep or standby the nonmaskable request is accepted despite the block bit.
// R4 - A control bit makes nonmaskable requests accepted while the block bit is set.
// R5 - Nonmaskable pin is edge detected; edge-select bit picks rising or falling.
// R6 - After an edge-select write, nonmaskable edges are ignored for 6 bus clocks.
// R7 - Nonmaskable exception handling leaves the cpu mask level bits unchanged.
// R8 - Encoded pins are a level: 0000 is level 15, 1111 is no request.
// R9 - Encoded pins sampled every clock; new level after three identical samples.
// R10 - In standby the encoded filter steps on the 32.768 kHz clock instead.
// R11 - External logic holds its encoded level until accepted; raising is allowed.
// R12 - Encoded-level handling leaves the cpu mask level bits unchanged.
// R13 - Independent mode bit set makes the four pins four separate requests.
// R14 - Encoded requests are masked by the cpu mask level; nonmaskable is not.
// R15 - A readable bit shows the current nonmaskable pin level.
// R16 - Control register resets to 0x8000 with pin high, 0x0000 with pin low.
// R17 - Power-on and manual reset both load all initial register values.
// R18 - Five priority registers give each peripheral source one of 15 levels.
// R19 - Equal-level simultaneous requests resolve in a fixed default order.
// R20 - Each source is reported to the cpu with a unique event code.
// R21 - Request the cpu only when best level exceeds mask level, or nmi accepted.
package irq_front_pkg;

  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [31:0] ADDR_EXT_PRIO_MAP = 32'hfe080000;
  localparam logic [31:0] ADDR_PENDING = 32'hfe080020;
  localparam logic [31:0] ADDR_MASK_SET = 32'hfe080040;
  localparam logic [31:0] ADDR_MASK_CLEAR = 32'hfe080060;
  localparam logic [31:0] ADDR_CONTROL = 32'hffd00000;
  localparam logic [31:0] ADDR_PRIO_A = 32'hffd00004;
  localparam logic [31:0] ADDR_PRIO_B = 32'hffd00008;
  localparam logic [31:0] ADDR_PRIO_C = 32'hffd0000c;
  localparam logic [31:0] ADDR_PRIO_D = 32'hffd00010;

  // ------------------------------------------------------------
  // Reset values and control fields
  // ------------------------------------------------------------
  localparam logic [31:0] RST_EXT_PRIO_MAP = 32'h00000000;
  localparam logic [31:0] RST_MASK = 32'h000003ff;
  localparam logic [15:0] RST_PRIO_ABC = 16'h0000;
  localparam logic [15:0] RST_PRIO_D = 16'hda74;
  localparam int CTL_NMI_LEVEL_BIT = 15;
  localparam int CTL_ACCEPT_ALL_BIT = 9;
  localparam int CTL_EDGE_SEL_BIT = 8;
  localparam int CTL_INDEP_BIT = 7;

  // ------------------------------------------------------------
  // Sources, levels and event codes
  // ------------------------------------------------------------
  localparam int NUM_GROUP_SRC = 12;
  localparam int NUM_MAP_SRC = 8;
  localparam int NUM_PERIPH = NUM_GROUP_SRC + NUM_MAP_SRC;
  localparam int NUM_CAND = NUM_PERIPH + 6;
  localparam logic [4:0] LEVEL_NMI = 5'h10;
  localparam logic [3:0] IRL_NONE = 4'hf;
  localparam logic [11:0] CODE_NMI = 12'h1c0;
  localparam logic [11:0] CODE_IRL_BASE = 12'h200;
  localparam logic [11:0] CODE_IRL0 = 12'h240;
  localparam logic [11:0] CODE_IRL1 = 12'h2a0;
  localparam logic [11:0] CODE_IRL2 = 12'h300;
  localparam logic [11:0] CODE_IRL3 = 12'h360;
  localparam logic [11:0] CODE_PERIPH_BASE = 12'h400;
  localparam logic [11:0] CODE_STEP = 12'h020;

  // ------------------------------------------------------------
  // Timing counts
  // ------------------------------------------------------------
  localparam logic [2:0] EDGE_BLIND_CYCLES = 3'd6;
  localparam logic [1:0] FILTER_SAMPLES = 2'd3;
  localparam logic [1:0] NMI_PRIME_CYCLES = 2'd3;

endpackage
